/* File: hdl/cirp_params.svh */
// constants for the command and interrupt register page
`ifndef CIRP_PARAMS_SVH
`define CIRP_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CIRP_OFF_RESERVED    6'h00
`define CIRP_OFF_COMMAND     6'h01
`define CIRP_OFF_MAIN_EN     6'h02
`define CIRP_OFF_SEC_EN      6'h03
`define CIRP_OFF_MAIN_REQ    6'h04
`define CIRP_OFF_SEC_REQ     6'h05

// ----------------------------------------
// reset values
// ----------------------------------------
`define CIRP_RST_COMMAND     8'h20
`define CIRP_RST_MAIN_EN     8'h80
`define CIRP_RST_SEC_EN      8'h00
`define CIRP_RST_MAIN_REQ    8'h14
`define CIRP_RST_SEC_REQ     8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define CIRP_BIT_RCV_OFF     5
`define CIRP_BIT_POWER_DOWN  4
`define CIRP_BIT_INVERT      7
`define CIRP_BIT_PUSH_PULL   7
`define CIRP_BIT_EXTERNAL_SERIAL_INPUT        4
`define CIRP_BIT_CRC         2
`define CIRP_BIT_SET_SELECT  7
`define CIRP_BIT_IDLE        4
`define CIRP_SEC_MASK        8'h94
`define CIRP_SEC_REQ_MASK    8'h14

// ----------------------------------------
// command codes
// ----------------------------------------
`define CIRP_CMD_IDLE        4'h0
`define CIRP_CMD_SOFT_RESET  4'hf
`define CIRP_KNOWN_CMD_MASK  16'hf0ff

// ----------------------------------------
// timing
// ----------------------------------------
`define CIRP_CLK_PERIOD_NS   25
`define CIRP_WAKE_TIME_NS    1000
`define CIRP_WAKE_CYCLES     ((`CIRP_WAKE_TIME_NS + `CIRP_CLK_PERIOD_NS - 1) / `CIRP_CLK_PERIOD_NS)

`endif

/* File: hdl/cirp_pkg.sv */
// types shared by the command and interrupt register page
package cirp_pkg;

	// ----------------------------------------
	// host register port
	// ----------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [5:0] addr;
		logic [7:0] wdata;
	} cirp_bus_req_t;

	// ----------------------------------------
	// one-cycle events from the reader core
	// ----------------------------------------
	typedef struct packed {
		logic transmit_done;
		logic receive_done;
		logic high_alert;
		logic low_alert;
		logic error_seen;
		logic timer_zero;
		logic crc_done;
	} cirp_events_t;

	// ----------------------------------------
	// power state
	// ----------------------------------------
	typedef enum logic [1:0] {
		CIRP_PS_RUN  = 2'b00,
		CIRP_PS_DOWN = 2'b01,
		CIRP_PS_WAKE = 2'b10
	} cirp_power_t;

endpackage : cirp_pkg

/* File: hdl/cirp_top.sv */
// command, interrupt enable and interrupt request register page with irq pin
//
// What this block does
// - offset zero is reserved, does nothing and reads zero.
// - command register at offset one, resets to 0x20.
// - receiver off bit set powers down the receiver analog part.
// - writing one to power-down bit enters soft power-down.
// - clearing power-down starts wake-up; bit reads one until ready.
// - power-down cannot be set while soft reset command is active.
// - low four bits launch a command; read shows the running command.
// - main enable register at offset two, resets to 0x80.
// - invert bit one makes irq pin the inverse of status.
// - reset values leave the irq pin undriven.
// - each main enable bit below seven gates its matching request onto the pin.
// - secondary enable at offset three, resets zero, some bits reserved.
// - push-pull bit chooses cmos drive, else open-drain.
// - secondary bit four enables external input activity request.
// - secondary bit two enables crc complete request.
// - main request at offset four, resets 0x14, bit seven write-only.
// - writing marks flags; bit seven chooses set or clear.
// - transmit flag set right after last outgoing bit.
// - idle flag on command end or unknown command, not host idle.
// - timer flag set when timer reaches zero.
`timescale 1ns/1ps
`include "cirp_params.svh"

module cirp_top (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  cirp_pkg::cirp_bus_req_t    bus_req,
	output logic [7:0]                 bus_rdata,
	input  cirp_pkg::cirp_events_t     core_events,
	input  wire logic                  command_done,
	input  wire logic                  external_serial_input,
	output logic [3:0]                 command_code,
	output logic                       command_start,
	output logic                       receiver_off,
	output logic                       soft_power_down,
	output logic                       irq_out,
	output logic                       irq_oe
);
	import cirp_pkg::*;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic addr_hit(input logic [5:0] addr, input logic [5:0] offset);
		addr_hit = (addr == offset);
	endfunction

	function automatic logic known_cmd(input logic [3:0] code);
		logic [15:0] mask;
		mask      = `CIRP_KNOWN_CMD_MASK;
		known_cmd = mask[code];
	endfunction

	// a hardware set beats a software clear landing in the same cycle
	function automatic logic flag_next(input logic hw, input logic mark, input logic sel, input logic cur);
		flag_next = hw | (mark & sel) | (cur & ~(mark & ~sel));
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [3:0]  cmd_reg;
	logic [3:0]  cmd_next;
	logic        start_reg;
	logic        start_next;
	logic        rcv_off_reg;
	logic        pd_bit_reg;
	logic        pd_bit_next;
	cirp_power_t ps_reg;
	cirp_power_t ps_next;
	logic [7:0]  main_en_reg;
	logic [7:0]  sec_en_reg;
	logic [6:0]  main_req_reg;
	logic [6:0]  main_req_next;
	logic        external_serial_input_req_reg;
	logic        external_serial_input_req_next;
	logic        crc_req_reg;
	logic        crc_req_next;
	logic [7:0]  rdata_reg;
	logic        irq_out_reg;
	logic        irq_oe_reg;
	logic        external_serial_input_meta_reg;
	logic        external_serial_input_sync_reg;
	logic        external_serial_input_last_reg;
	logic [2:0]  external_serial_input_primed_reg;
	logic        wake_done;

	// ----------------------------------------
	// register port decode
	// ----------------------------------------
	wire       wr_cmd      = bus_req.wr & addr_hit(bus_req.addr, `CIRP_OFF_COMMAND);
	wire       wr_main_en  = bus_req.wr & addr_hit(bus_req.addr, `CIRP_OFF_MAIN_EN);
	wire       wr_sec_en   = bus_req.wr & addr_hit(bus_req.addr, `CIRP_OFF_SEC_EN);
	wire       wr_main_req = bus_req.wr & addr_hit(bus_req.addr, `CIRP_OFF_MAIN_REQ);
	wire       wr_sec_req  = bus_req.wr & addr_hit(bus_req.addr, `CIRP_OFF_SEC_REQ);
	wire [3:0] wr_code     = bus_req.wdata[3:0];
	wire       set_select  = bus_req.wdata[`CIRP_BIT_SET_SELECT];

	// ----------------------------------------
	// command launch and termination
	// ----------------------------------------
	wire cmd_running  = (cmd_reg != `CIRP_CMD_IDLE);
	wire launch_known = wr_cmd & known_cmd(wr_code) & (wr_code != `CIRP_CMD_IDLE);
	wire launch_bad   = wr_cmd & ~known_cmd(wr_code);
	wire core_ends    = command_done & cmd_running & ~wr_cmd;
	// host writing idle clears the code silently
	wire idle_event   = launch_bad | core_ends;

	always_comb
	begin
		cmd_next   = cmd_reg;
		start_next = 1'b0;
		if (wr_cmd)
		begin
			cmd_next   = launch_bad ? `CIRP_CMD_IDLE : wr_code;
			start_next = launch_known;
		end
		else if (core_ends)
		begin
			cmd_next = `CIRP_CMD_IDLE;
		end
	end

	// ----------------------------------------
	// soft power-down sequencing
	// ----------------------------------------
	wire soft_reset_active = (cmd_reg == `CIRP_CMD_SOFT_RESET) | (wr_code == `CIRP_CMD_SOFT_RESET);
	wire pd_request        = wr_cmd & bus_req.wdata[`CIRP_BIT_POWER_DOWN] & ~soft_reset_active;
	wire pd_release        = wr_cmd & ~bus_req.wdata[`CIRP_BIT_POWER_DOWN];
	wire wake_start        = (ps_reg == CIRP_PS_DOWN) & pd_release;

	always_comb
	begin
		ps_next = ps_reg;
		case (ps_reg)
			CIRP_PS_RUN:
			begin
				if (pd_request)
					ps_next = CIRP_PS_DOWN;
			end
			CIRP_PS_DOWN:
			begin
				if (pd_release)
					ps_next = CIRP_PS_WAKE;
			end
			CIRP_PS_WAKE:
			begin
				// a new power-down write during wake-up is not honoured
				if (wake_done)
					ps_next = CIRP_PS_RUN;
			end
			default:
			begin
				ps_next = CIRP_PS_RUN;
			end
		endcase
	end

	// bit stays one through wake-up, drops only when ready
	assign pd_bit_next = (ps_next != CIRP_PS_RUN);

	cirp_wake u_wake (
		.clk   (clk),
		.rst   (rst),
		.start (wake_start),
		.done  (wake_done)
	);

	// ----------------------------------------
	// external input activity detect
	// ----------------------------------------
	// edges count only once the chain holds real pin samples, so reset never
	// fakes one; an edge before the first clock after reset is lost
	wire external_serial_input_edge = external_serial_input_primed_reg[2] & (external_serial_input_sync_reg ^ external_serial_input_last_reg);

	// ----------------------------------------
	// request flags: hardware set wins over software clear
	// ----------------------------------------
	wire [6:0] hw_set = {core_events.transmit_done,
	                     core_events.receive_done,
	                     idle_event,
	                     core_events.high_alert,
	                     core_events.low_alert,
	                     core_events.error_seen,
	                     core_events.timer_zero};

	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++)
		begin : g_main_req
			wire mark = wr_main_req & bus_req.wdata[gi];
			// marked flags follow the set-select bit
			assign main_req_next[gi] = flag_next(hw_set[gi], mark, set_select, main_req_reg[gi]);
		end
	endgenerate

	wire mark_external_serial_input = wr_sec_req & bus_req.wdata[`CIRP_BIT_EXTERNAL_SERIAL_INPUT];
	wire mark_crc  = wr_sec_req & bus_req.wdata[`CIRP_BIT_CRC];
	assign external_serial_input_req_next = flag_next(external_serial_input_edge, mark_external_serial_input, set_select, external_serial_input_req_reg);
	assign crc_req_next  = flag_next(core_events.crc_done, mark_crc, set_select, crc_req_reg);

	// ----------------------------------------
	// interrupt status and pin drive
	// ----------------------------------------
	wire main_hit   = |(main_req_reg & main_en_reg[6:0]);
	wire external_serial_input_hit   = external_serial_input_req_reg & sec_en_reg[`CIRP_BIT_EXTERNAL_SERIAL_INPUT];
	wire crc_hit    = crc_req_reg & sec_en_reg[`CIRP_BIT_CRC];
	wire irq_status = main_hit | external_serial_input_hit | crc_hit;
	wire pin_level  = irq_status ^ main_en_reg[`CIRP_BIT_INVERT];
	wire push_pull  = sec_en_reg[`CIRP_BIT_PUSH_PULL];
	// open-drain pulls low only, a high level is released to the pull-up
	wire irq_out_next = push_pull ? pin_level : 1'b0;
	wire irq_oe_next  = push_pull ? 1'b1 : ~pin_level;

	// ----------------------------------------
	// read data
	// ----------------------------------------
	wire [7:0] rd_command  = {2'b00, rcv_off_reg, pd_bit_reg, cmd_reg};
	wire [7:0] rd_main_req = {1'b0, main_req_reg};
	wire [7:0] rd_sec_req  = {3'b000, external_serial_input_req_reg, 1'b0, crc_req_reg, 2'b00};
	wire [7:0] rd_value    =
		addr_hit(bus_req.addr, `CIRP_OFF_RESERVED) ? 8'h00 :
		addr_hit(bus_req.addr, `CIRP_OFF_COMMAND)  ? rd_command :
		addr_hit(bus_req.addr, `CIRP_OFF_MAIN_EN)  ? main_en_reg :
		addr_hit(bus_req.addr, `CIRP_OFF_SEC_EN)   ? sec_en_reg :
		addr_hit(bus_req.addr, `CIRP_OFF_MAIN_REQ) ? rd_main_req :
		addr_hit(bus_req.addr, `CIRP_OFF_SEC_REQ)  ? rd_sec_req : 8'h00;
	wire [7:0] rdata_next  = bus_req.rd ? rd_value : 8'h00;

	// ----------------------------------------
	// command register
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cmd_reg     <= 4'(`CIRP_RST_COMMAND);
			rcv_off_reg <= 1'(`CIRP_RST_COMMAND >> `CIRP_BIT_RCV_OFF);
			start_reg   <= 1'b0;
		end
		else
		begin
			cmd_reg     <= cmd_next;
			start_reg   <= start_next;
			if (wr_cmd)
				rcv_off_reg <= bus_req.wdata[`CIRP_BIT_RCV_OFF];
		end
	end

	// ----------------------------------------
	// enable registers
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			main_en_reg <= `CIRP_RST_MAIN_EN;
			sec_en_reg  <= `CIRP_RST_SEC_EN;
		end
		else
		begin
			if (wr_main_en)
				main_en_reg <= bus_req.wdata;
			if (wr_sec_en)
				sec_en_reg <= bus_req.wdata & `CIRP_SEC_MASK;
		end
	end

	// ----------------------------------------
	// power and request flag registers
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ps_reg       <= CIRP_PS_RUN;
			pd_bit_reg   <= 1'b0;
			main_req_reg <= 7'(`CIRP_RST_MAIN_REQ);
			external_serial_input_req_reg <= 1'b0;
			crc_req_reg  <= 1'b0;
		end
		else
		begin
			ps_reg       <= ps_next;
			pd_bit_reg   <= pd_bit_next;
			main_req_reg <= main_req_next;
			external_serial_input_req_reg <= external_serial_input_req_next;
			crc_req_reg  <= crc_req_next;
		end
	end

	// ----------------------------------------
	// pin and read registers
	// ----------------------------------------
	// the pin is registered so a status change never glitches it
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			irq_out_reg <= 1'b0;
			irq_oe_reg  <= 1'b0;
			rdata_reg   <= 8'h00;
		end
		else
		begin
			irq_out_reg <= irq_out_next;
			irq_oe_reg  <= irq_oe_next;
			rdata_reg   <= rdata_next;
		end
	end

	// ----------------------------------------
	// external input synchroniser
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			external_serial_input_meta_reg <= 1'b0;
			external_serial_input_sync_reg <= 1'b0;
			external_serial_input_last_reg <= 1'b0;
			external_serial_input_primed_reg <= 3'b000;
		end
		else
		begin
			external_serial_input_meta_reg <= external_serial_input;
			external_serial_input_sync_reg <= external_serial_input_meta_reg;
			external_serial_input_last_reg <= external_serial_input_sync_reg;
			external_serial_input_primed_reg <= {external_serial_input_primed_reg[1:0], 1'b1};
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign bus_rdata       = rdata_reg;
	assign command_code    = cmd_reg;
	assign command_start   = start_reg;
	assign receiver_off    = rcv_off_reg;
	assign soft_power_down = pd_bit_reg;
	assign irq_out         = irq_out_reg;
	assign irq_oe          = irq_oe_reg;

endmodule // cirp_top

/* File: hdl/cirp_wake.sv */
// wake-up delay counter for leaving soft power-down
`timescale 1ns/1ps
`include "cirp_params.svh"

module cirp_wake (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic start,
	output logic      done
);
	import cirp_pkg::*;

	localparam int        WAKE_CYCLES = `CIRP_WAKE_CYCLES;
	localparam logic [7:0] LAST       = 8'(WAKE_CYCLES - 1);

	logic [7:0] count_reg;
	logic       busy_reg;
	logic       done_reg;
	wire        at_last = busy_reg && (count_reg == LAST);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			count_reg <= 8'h00;
			busy_reg  <= 1'b0;
			done_reg  <= 1'b0;
		end
		else
		begin
			done_reg  <= at_last;
			busy_reg  <= start | (busy_reg & ~at_last);
			count_reg <= (start | at_last) ? 8'h00 : (busy_reg ? count_reg + 8'h01 : count_reg);
		end
	end

	assign done = done_reg;

endmodule // cirp_wake

/* File: testbench/cirp_host.sv */
// host model: register port master and pulled-up irq pin
`timescale 1ns/1ps

module cirp_host (
	input  wire logic               clk,
	output cirp_pkg::cirp_bus_req_t bus_req,
	input  wire logic [7:0]         bus_rdata,
	input  wire logic               irq_out,
	input  wire logic               irq_oe,
	output logic                    irq_pin
);
	import cirp_pkg::*;

	// undriven pin floats up through the board resistor
	assign irq_pin = irq_oe ? irq_out : 1'b1;

	initial
		bus_req = '0;

	task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		bus_req.wr <= 1'b0;
		#1;
	endtask

	task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1;
		d = bus_rdata;
	endtask

	// top bit picks set or clear for the marked flags
	task automatic set_flags(input logic [5:0] a, input logic [6:0] m, input logic s);
		wr_reg(a, {s, m});
	endtask
endmodule // cirp_host

/* File: testbench/cirp_sva.sv */
// port assertions for the command and interrupt register page
`timescale 1ns/1ps

module cirp_sva (
	input wire logic               clk,
	input wire logic               rst,
	input cirp_pkg::cirp_bus_req_t bus_req,
	input wire logic [7:0]         bus_rdata,
	input cirp_pkg::cirp_events_t  core_events,
	input wire logic [3:0]         command_code,
	input wire logic               command_start,
	input wire logic               receiver_off,
	input wire logic               soft_power_down,
	input wire logic               irq_out,
	input wire logic               irq_oe
);
	import cirp_pkg::*;

	// ----------------------------------------
	// shadow of the pin controls
	// ----------------------------------------
	logic [7:0] main_en_sh;
	logic       pp_sh;
	wire logic  cmd_wr   = bus_req.wr && bus_req.addr == 6'h01;
	wire logic  pd_clear = cmd_wr && !bus_req.wdata[4] && soft_power_down;

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			main_en_sh <= 8'h80;
			pp_sh      <= 1'b0;
		end
		else if (bus_req.wr)
		begin
			if (bus_req.addr == 6'h02)
				main_en_sh <= bus_req.wdata;
			if (bus_req.addr == 6'h03)
				pp_sh <= bus_req.wdata[7];
		end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	property p_rsvd_read; bus_req.rd && bus_req.addr == 6'h00 |=> bus_rdata == 8'h00; endproperty
	a_rsvd_read: assert property (p_rsvd_read) else $error("reserved slot read nonzero");
	property p_cmd_rsvd; bus_req.rd && bus_req.addr == 6'h01 |=> bus_rdata[7:6] == 2'b00; endproperty
	a_cmd_rsvd: assert property (p_cmd_rsvd) else $error("command spare bits read nonzero");
	property p_rcv_off; cmd_wr |=> receiver_off == $past(bus_req.wdata[5]); endproperty
	a_rcv_off: assert property (p_rcv_off) else $error("receiver off not following write");
	property p_known;
		cmd_wr && bus_req.wdata[3:0] inside {[1:7], [12:15]}
			|=> command_start && command_code == $past(bus_req.wdata[3:0]);
	endproperty
	a_known: assert property (p_known) else $error("known command not launched");
	property p_unknown; cmd_wr && bus_req.wdata[3:0] inside {[8:11]} |=> !command_start && command_code == 4'h0; endproperty
	a_unknown: assert property (p_unknown) else $error("unknown command not reverted");
	property p_start_cause; command_start |-> $past(bus_req.wr) && $past(bus_req.addr) == 6'h01; endproperty
	a_start_cause: assert property (p_start_cause) else $error("start pulse without command write");
	property p_pd_enter;
		cmd_wr && bus_req.wdata[4] && bus_req.wdata[3:0] != 4'hf && command_code != 4'hf && !soft_power_down
			|=> soft_power_down;
	endproperty
	a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");
	property p_pd_refuse; cmd_wr && bus_req.wdata[4] && bus_req.wdata[3:0] == 4'hf && !soft_power_down |=> !soft_power_down; endproperty
	a_pd_refuse: assert property (p_pd_refuse) else $error("power-down taken during soft reset");
	property p_wake_hold; pd_clear |=> soft_power_down [*8]; endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("wake-up ended too soon");
	property p_wake_bound; pd_clear |-> ##[40:43] !soft_power_down; endproperty
	a_wake_bound: assert property (p_wake_bound) else $error("wake-up did not finish in time");
	property p_od; irq_out |-> irq_oe; endproperty
	a_od: assert property (p_od) else $error("pin high while undriven");
	property p_reset_pin; $fell(rst) |-> !irq_oe && !irq_out; endproperty
	a_reset_pin: assert property (p_reset_pin) else $error("pin driven after reset");
	property p_event_pin;
		(core_events.timer_zero && main_en_sh[0] && pp_sh && !bus_req.wr) ##1 !bus_req.wr
			|-> ##1 irq_oe && irq_out == !main_en_sh[7];
	endproperty
	a_event_pin: assert property (p_event_pin) else $error("enabled event did not reach pin");

	c_wake: cover property (pd_clear);
	c_event_pin: cover property (core_events.timer_zero && main_en_sh[0] && pp_sh);
	c_unknown: cover property (cmd_wr && bus_req.wdata[3:0] == 4'h8);
endmodule // cirp_sva

bind cirp_top cirp_sva u_cirp_sva (
	.clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .core_events(core_events),
	.command_code(command_code), .command_start(command_start), .receiver_off(receiver_off),
	.soft_power_down(soft_power_down), .irq_out(irq_out), .irq_oe(irq_oe)
);

/* File: testbench/tb_top.sv */
// self-checking bench for the command and interrupt register page
`timescale 1ns/1ps

module tb_top;
	import cirp_pkg::*;

	typedef struct packed {
		logic       wr;
		logic [5:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
	} cirp_tb_row_t;

	logic          clk = 1'b0;
	logic          rst = 1'b1;
	cirp_bus_req_t bus_req;
	logic [7:0]    bus_rdata;
	cirp_events_t  core_events = '0;
	logic          command_done = 1'b0;
	logic          ser_in = 1'b0;
	logic [3:0]    command_code;
	logic          command_start;
	logic          receiver_off;
	logic          soft_power_down;
	logic          irq_out;
	logic          irq_oe;
	logic          irq_pin;
	int            err_count = 0;
	int            comparisons = 0;
	int            n;
	logic [7:0]    ev_main [7] = '{8'h40, 8'h20, 8'h08, 8'h04, 8'h02, 8'h01, 8'h00};
	cirp_tb_row_t  rows [18] = '{
		'{1'b0, 6'h00, 8'h00, 8'h00}, '{1'b0, 6'h01, 8'h00, 8'h20}, '{1'b0, 6'h02, 8'h00, 8'h80},
		'{1'b0, 6'h03, 8'h00, 8'h00}, '{1'b0, 6'h04, 8'h00, 8'h14}, '{1'b0, 6'h05, 8'h00, 8'h00},
		'{1'b1, 6'h00, 8'hff, 8'h00}, '{1'b1, 6'h03, 8'hff, 8'h94}, '{1'b1, 6'h02, 8'h7f, 8'h7f},
		'{1'b1, 6'h04, 8'h14, 8'h00}, '{1'b1, 6'h04, 8'hff, 8'h7f}, '{1'b1, 6'h04, 8'h7f, 8'h00},
		'{1'b1, 6'h01, 8'he3, 8'h23}, '{1'b1, 6'h01, 8'h00, 8'h00}, '{1'b0, 6'h04, 8'h00, 8'h00},
		'{1'b1, 6'h01, 8'h08, 8'h00}, '{1'b0, 6'h04, 8'h00, 8'h10}, '{1'b1, 6'h2a, 8'hff, 8'h00}};

	always #12.5 clk = ~clk;

	cirp_top u_cirp_top (
		.clk                  (clk),
		.rst                  (rst),
		.bus_req              (bus_req),
		.bus_rdata            (bus_rdata),
		.core_events          (core_events),
		.command_done         (command_done),
		.external_serial_input(ser_in),
		.command_code         (command_code),
		.command_start        (command_start),
		.receiver_off         (receiver_off),
		.soft_power_down      (soft_power_down),
		.irq_out              (irq_out),
		.irq_oe               (irq_oe)
	);

	cirp_host u_cirp_host (
		.clk      (clk),
		.bus_req  (bus_req),
		.bus_rdata(bus_rdata),
		.irq_out  (irq_out),
		.irq_oe   (irq_oe),
		.irq_pin  (irq_pin)
	);

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
		logic [7:0] v;
		u_cirp_host.rd_reg(a, v);
		chk(v, exp);
	endtask

	task automatic pulse(input cirp_events_t ev);
		@(posedge clk);
		core_events <= ev;
		@(posedge clk);
		core_events <= '0;
		#1;
	endtask

	// pin lags the register write by one more cycle
	task automatic pin_chk(input logic [7:0] exp);
		repeat (2) @(posedge clk);
		#1;
		chk(8'({irq_pin, irq_oe, irq_out}), exp);
	endtask

	task automatic end_sim;
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk(8'({irq_oe, irq_out}), 8'h00);
		chk(8'({receiver_off, soft_power_down, command_code}), 8'h20);
		for (int i = 0; i < 18; i++)
		begin
			if (rows[i].wr)
				u_cirp_host.wr_reg(rows[i].addr, rows[i].wdata);
			rd_chk(rows[i].addr, rows[i].exp);
		end
		u_cirp_host.set_flags(6'h04, 7'h7f, 1'b0);
		u_cirp_host.wr_reg(6'h01, 8'h25);
		chk(8'({command_start, receiver_off, command_code}), 8'h35);
		@(posedge clk);
		command_done <= 1'b1;
		@(posedge clk);
		command_done <= 1'b0;
		rd_chk(6'h01, 8'h20);
		rd_chk(6'h04, 8'h10);
		for (int k = 0; k < 7; k++)
		begin
			u_cirp_host.set_flags(6'h04, 7'h7f, 1'b0);
			u_cirp_host.set_flags(6'h05, 7'h7f, 1'b0);
			pulse(cirp_events_t'(7'h40 >> k));
			rd_chk(6'h04, ev_main[k]);
			rd_chk(6'h05, (k == 6) ? 8'h04 : 8'h00);
		end
		// a timer event and a clear of its flag on one edge: the event wins
		fork
			u_cirp_host.set_flags(6'h04, 7'h01, 1'b0);
			pulse(cirp_events_t'(7'h02));
		join
		rd_chk(6'h04, 8'h01);
		u_cirp_host.set_flags(6'h05, 7'h7f, 1'b0);
		for (int i = 0; i < 7; i++)
		begin
			u_cirp_host.set_flags(6'h04, 7'h7f, 1'b0);
			u_cirp_host.wr_reg(6'h02, 8'h01 << i);
			u_cirp_host.set_flags(6'h04, 7'(7'h01 << i), 1'b1);
			pin_chk(8'h07);
			u_cirp_host.wr_reg(6'h02, 8'h80 | (8'h01 << i));
			pin_chk(8'h02);
			u_cirp_host.wr_reg(6'h02, 8'h7f & ~(8'h01 << i));
			pin_chk(8'h02);
		end
		u_cirp_host.wr_reg(6'h03, 8'h00);
		u_cirp_host.wr_reg(6'h02, 8'h40);
		pin_chk(8'h04);
		u_cirp_host.wr_reg(6'h02, 8'hc0);
		pin_chk(8'h02);
		u_cirp_host.wr_reg(6'h02, 8'h80);
		pin_chk(8'h04);
		u_cirp_host.set_flags(6'h04, 7'h7f, 1'b0);
		u_cirp_host.wr_reg(6'h02, 8'h00);
		u_cirp_host.wr_reg(6'h03, 8'h90);
		@(posedge clk);
		ser_in <= 1'b1;
		repeat (6) @(posedge clk);
		rd_chk(6'h05, 8'h10);
		pin_chk(8'h07);
		u_cirp_host.wr_reg(6'h03, 8'h84);
		pin_chk(8'h02);
		pulse(cirp_events_t'(7'h01));
		pin_chk(8'h07);
		u_cirp_host.wr_reg(6'h01, 8'h10);
		chk(8'(soft_power_down), 8'h01);
		u_cirp_host.wr_reg(6'h01, 8'h00);
		rd_chk(6'h01, 8'h10);
		n = 0;
		while (soft_power_down === 1'b1 && n < 60)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 60)
		begin
			err_count++;
			end_sim();
		end
		chk(8'(n > 37 && n < 42), 8'h01);
		rd_chk(6'h01, 8'h00);
		u_cirp_host.wr_reg(6'h01, 8'h0f);
		u_cirp_host.wr_reg(6'h01, 8'h1f);
		chk(8'({soft_power_down, command_code}), 8'h0f);
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk(8'({irq_oe, irq_out, soft_power_down, command_start}), 8'h00);
		rd_chk(6'h01, 8'h20);
		rd_chk(6'h02, 8'h80);
		rd_chk(6'h04, 8'h14);
		// the external input sits high across reset and must not fake an edge
		rd_chk(6'h05, 8'h00);
		end_sim();
	end
endmodule // tb_top
